/* File: common/scl_pkg.sv */
// Shared constants and types for the configuration load sequencer
package scl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SCL_WORD_W = 32;
  localparam int SCL_ADDR_W = 16;
  localparam int SCL_BUS_AW = 4;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [SCL_BUS_AW-1:0] SCL_OFS_CTRL = 4'h0;
  localparam logic [SCL_BUS_AW-1:0] SCL_OFS_STATUS = 4'h4;
  localparam logic [SCL_BUS_AW-1:0] SCL_OFS_DATA = 4'h8;
  localparam int SCL_CTRL_SCHEME_LSB = 0;
  localparam int SCL_CTRL_RECONFIG_BIT = 2;
  localparam int SCL_CTRL_ABORT_BIT = 3;
  localparam int SCL_STAT_USER_BIT = 3;
  localparam int SCL_STAT_ERROR_BIT = 4;
  localparam int SCL_STAT_PIN_BIT = 5;
  localparam int SCL_STAT_CHAIN_BIT = 6;
  localparam int SCL_STAT_COUNT_LSB = 16;
  localparam logic [1:0] SCL_CTRL_SCHEME_RESET = 2'h0;
  localparam logic [3:0] SCL_FULL_LANES = 4'hf;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SCL_CLK_MHZ = 100;
  localparam int SCL_SERIAL_MHZ = 20;
  localparam int SCL_AS_DIV = SCL_CLK_MHZ / SCL_SERIAL_MHZ;
  localparam int SCL_AS_HIGH = SCL_AS_DIV / 2;
  localparam int SCL_LOAD_LIMIT_MS = 120;
  localparam int SCL_LOAD_LIMIT_CYCLES = SCL_LOAD_LIMIT_MS * 1000 * SCL_CLK_MHZ;
  localparam int SCL_INIT_CYCLES = 8;
  localparam int SCL_FIFO_DEPTH = 32;
  localparam int SCL_CFG_WORDS = 1024;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_powerup = 3'h0,
    st_wait_chain = 3'h1,
    st_load = 3'h2,
    st_init = 3'h3,
    st_user = 3'h4,
    st_reset_hold = 3'h5,
    st_abort = 3'h6
  } scl_state_t;

  typedef enum logic [1:0] {
    active_serial_scheme = 2'h0,
    passive_serial_scheme = 2'h1,
    scan_port_scheme = 2'h2
  } scl_scheme_t;

  typedef struct packed {
    logic [SCL_ADDR_W-1:0] addr;
    logic [SCL_WORD_W-1:0] data;
  } scl_store_wr_t;

endpackage

/* File: core/scl_sequencer.sv */
// Configuration load sequencer with its word FIFO
// What this block does
// - Power-up always loads store before user function
// - After load: clear registers, enable I/O, run
// - Command mode and user mode kept distinct
// - Reconfig request returns to command mode, reloads
// - User I/O pulled high until configured
// - Exactly one of three load schemes active
// - Active serial: device clocks serial memory itself
// - Full load must finish within 120 ms
// - Chain enable in/out daisy-chains several devices
// - Abort pulls status pin low until reconfigured
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps

module scl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[PW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // scl_fifo

module scl_sequencer #(
  parameter int CFG_WORDS = scl_pkg::SCL_CFG_WORDS,
  parameter int LOAD_LIMIT_CYCLES = scl_pkg::SCL_LOAD_LIMIT_CYCLES,
  parameter int FIFO_DEPTH = scl_pkg::SCL_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire logic [scl_pkg::SCL_BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Chain and control pins
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  input wire logic reconfig_request_n,
  input wire logic config_status_n_in,
  output logic config_status_n_out,
  output logic config_status_n_oe,
  // Serial configuration memory
  output logic as_sclk,
  output logic as_cs_n,
  input wire logic as_miso,
  // Passive serial source
  input wire logic ps_dclk,
  input wire logic ps_data,
  output logic load_ready,
  // Boundary-scan source
  input wire logic scan_bit,
  input wire logic scan_bit_valid,
  // Configuration store
  output scl_pkg::scl_store_wr_t store_wr,
  output logic store_wr_valid,
  input wire logic store_wr_ready,
  output logic store_clear,
  // User side
  output logic user_mode,
  output logic user_io_pullup,
  output logic user_io_enable
);
  import scl_pkg::*;

  localparam int CW = $clog2(CFG_WORDS + 1);
  localparam int TW = $clog2(LOAD_LIMIT_CYCLES + 1);
  localparam logic [CW-1:0] LAST_WORD = CW'(CFG_WORDS);
  localparam logic [TW-1:0] LIMIT_LAST = TW'(LOAD_LIMIT_CYCLES - 1);
  localparam logic [3:0] INIT_LAST = 4'(SCL_INIT_CYCLES - 1);
  localparam logic [2:0] DIV_LAST = 3'(SCL_AS_DIV - 1);
  localparam logic [2:0] DIV_HIGH = 3'(SCL_AS_HIGH);

  scl_state_t state;
  scl_state_t next_state;
  scl_scheme_t scheme;
  scl_scheme_t load_scheme;
  logic soft_reconfig;
  logic soft_abort;
  logic error_seen;
  logic [TW-1:0] load_timer;
  logic [3:0] init_cnt;
  logic [2:0] div_cnt;
  logic ps_dclk_q;
  logic [31:0] shift;
  logic [4:0] bit_cnt;
  logic pend;
  logic [31:0] pend_word;
  logic [CW-1:0] pushed_cnt;
  logic [CW-1:0] written_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic in_load;
  logic src_open;
  logic as_take;
  logic ps_take;
  logic scan_take;
  logic bit_take;
  logic bit_val;
  logic bus_req;
  logic bus_commit;
  logic host_word;
  logic load_done;
  logic timeout;

  function automatic logic scheme_ok(input scl_scheme_t s);
    scheme_ok = (s == active_serial_scheme) || (s == passive_serial_scheme)
             || (s == scan_port_scheme);
  endfunction

  function automatic logic configured(input scl_state_t s);
    configured = (s == st_init) || (s == st_user);
  endfunction

  // ----------------------------------------------------------------
  // Top-level sequence
  // ----------------------------------------------------------------
  assign in_load = (state == st_load);
  assign load_done = (written_cnt == LAST_WORD);
  assign timeout = in_load && (load_timer == LIMIT_LAST);

  always_comb begin
    next_state = state;
    case (state)
      st_powerup: next_state = st_wait_chain;
      st_reset_hold: begin
        if (reconfig_request_n) begin
          next_state = st_wait_chain;
        end
      end
      st_wait_chain: begin
        if (!chain_enable_in_n) begin
          next_state = scheme_ok(scheme) ? st_load : st_abort;
        end
      end
      st_load: begin
        if (soft_abort || timeout) begin
          next_state = st_abort;
        end else if (load_done) begin
          next_state = st_init;
        end
      end
      st_init: begin
        if (init_cnt == INIT_LAST) begin
          next_state = st_user;
        end
      end
      st_user: next_state = st_user;
      st_abort: next_state = st_abort;
      default: next_state = st_reset_hold;
    endcase
    // Request pin outranks everything, even an abort
    if (!reconfig_request_n || soft_reconfig) begin
      next_state = st_reset_hold;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= st_powerup;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_timer <= '0;
      init_cnt <= '0;
    end else begin
      load_timer <= in_load ? load_timer + 1'b1 : '0;
      init_cnt <= (state == st_init) ? init_cnt + 1'b1 : '0;
    end
  end

  // Scheme is frozen for the whole load
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_scheme <= active_serial_scheme;
    end else if (state == st_wait_chain) begin
      load_scheme <= scheme;
    end
  end

  // ----------------------------------------------------------------
  // Pins and user-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      user_mode <= 1'b0;
      user_io_pullup <= 1'b1;
      user_io_enable <= 1'b0;
      chain_enable_out_n <= 1'b1;
      store_clear <= 1'b0;
      config_status_n_oe <= 1'b0;
      config_status_n_out <= 1'b0;
    end else begin
      user_mode <= (next_state == st_user);
      user_io_pullup <= !configured(next_state);
      user_io_enable <= configured(next_state);
      chain_enable_out_n <= !configured(next_state);
      store_clear <= (next_state == st_init) && (state != st_init);
      config_status_n_oe <= (next_state == st_abort);
      config_status_n_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      error_seen <= 1'b0;
    end else if (next_state == st_abort) begin
      error_seen <= 1'b1;
    end else if (state == st_reset_hold) begin
      error_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit sources
  // ----------------------------------------------------------------
  assign src_open = in_load && !pend && (pushed_cnt != LAST_WORD);
  // Clock stops while a word waits, so the memory is never overrun
  assign as_take = src_open && (load_scheme == active_serial_scheme)
                && (div_cnt == DIV_LAST);
  assign ps_take = src_open && (load_scheme == passive_serial_scheme)
                && ps_dclk && !ps_dclk_q;
  assign scan_take = src_open && (load_scheme == scan_port_scheme) && scan_bit_valid;
  assign bit_take = as_take || ps_take || scan_take;
  always_comb begin
    case (load_scheme)
      active_serial_scheme: bit_val = as_miso;
      passive_serial_scheme: bit_val = ps_data;
      default: bit_val = scan_bit;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_cnt <= '0;
      as_sclk <= 1'b0;
      as_cs_n <= 1'b1;
      ps_dclk_q <= 1'b0;
    end else begin
      ps_dclk_q <= ps_dclk;
      as_cs_n <= !(in_load && (load_scheme == active_serial_scheme));
      if (src_open && (load_scheme == active_serial_scheme)) begin
        div_cnt <= (div_cnt == DIV_LAST) ? 3'h0 : div_cnt + 1'b1;
        // Rises only after a sampled bit, so a resumed clock never shifts early
        as_sclk <= (div_cnt == DIV_LAST) || (as_sclk && (div_cnt < DIV_HIGH - 3'h1));
      end else begin
        div_cnt <= '0;
        as_sclk <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word assembly, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift <= '0;
      bit_cnt <= '0;
      pend <= 1'b0;
      pend_word <= '0;
      pushed_cnt <= '0;
    end else if (!in_load) begin
      bit_cnt <= '0;
      pend <= 1'b0;
      if (state == st_reset_hold) begin
        pushed_cnt <= '0;
      end
    end else begin
      if (pend && fifo_in_ready) begin
        pend <= 1'b0;
        pushed_cnt <= pushed_cnt + 1'b1;
      end else if (host_word) begin
        pend <= 1'b1;
        pend_word <= avs_writedata;
      end else if (bit_take) begin
        shift <= {shift[30:0], bit_val};
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == 5'h1f) begin
          pend <= 1'b1;
          pend_word <= {shift[30:0], bit_val};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_ready <= 1'b0;
    end else begin
      load_ready <= src_open && (load_scheme == passive_serial_scheme) && !bit_take;
    end
  end

  scl_fifo #(
    .WIDTH(SCL_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .flush(state == st_reset_hold),
    .in_valid(pend && in_load),
    .in_ready(fifo_in_ready),
    .in_data(pend_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Store write port
  // ----------------------------------------------------------------
  assign fifo_out_ready = in_load && (!store_wr_valid || store_wr_ready);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      store_wr <= '0;
      store_wr_valid <= 1'b0;
      written_cnt <= '0;
    end else if (state == st_reset_hold) begin
      store_wr_valid <= 1'b0;
      written_cnt <= '0;
    end else begin
      if (store_wr_valid && store_wr_ready) begin
        written_cnt <= written_cnt + 1'b1;
      end
      if (fifo_out_ready) begin
        store_wr_valid <= fifo_out_valid;
        store_wr.data <= fifo_out_data;
        store_wr.addr <= SCL_ADDR_W'(written_cnt + CW'(store_wr_valid && store_wr_ready));
      end else if (store_wr_ready) begin
        // Outside the load a held word is written once, never repeated
        store_wr_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Data writes wait while a word is still pending
  assign bus_req = avs_waitrequest && (avs_read || avs_write)
                && !(avs_write && avs_address == SCL_OFS_DATA && pend);
  assign bus_commit = !avs_waitrequest && avs_write;
  assign host_word = bus_commit && (avs_address == SCL_OFS_DATA)
                  && (avs_byteenable == SCL_FULL_LANES)
                  && (load_scheme == passive_serial_scheme);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        case (avs_address)
          SCL_OFS_CTRL: avs_readdata <= {30'h0, scheme};
          SCL_OFS_STATUS: begin
            avs_readdata <= '0;
            avs_readdata[2:0] <= state;
            avs_readdata[SCL_STAT_USER_BIT] <= user_mode;
            avs_readdata[SCL_STAT_ERROR_BIT] <= error_seen;
            avs_readdata[SCL_STAT_PIN_BIT] <= !config_status_n_in;
            avs_readdata[SCL_STAT_CHAIN_BIT] <= !chain_enable_in_n;
            avs_readdata[SCL_STAT_COUNT_LSB +: 16] <= 16'(written_cnt);
          end
          default: avs_readdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scheme <= scl_scheme_t'(SCL_CTRL_SCHEME_RESET);
      soft_reconfig <= 1'b0;
      soft_abort <= 1'b0;
    end else begin
      soft_reconfig <= 1'b0;
      soft_abort <= 1'b0;
      if (bus_commit && avs_address == SCL_OFS_CTRL && avs_byteenable[0]) begin
        scheme <= scl_scheme_t'(avs_writedata[SCL_CTRL_SCHEME_LSB +: 2]);
        soft_reconfig <= avs_writedata[SCL_CTRL_RECONFIG_BIT];
        soft_abort <= avs_writedata[SCL_CTRL_ABORT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_load_to_init;
    (state == st_load) ##1 (state == st_init);
  endsequence

  property p_user_after_load;
    $rose(user_mode) |-> $past(state, 2) == st_init;
  endproperty
  a_user_after_load: assert property (p_user_after_load) else $error("user mode without init");

  property p_init_clears;
    s_load_to_init |-> store_clear ##1 !store_clear ##[1:8] user_mode;
  endproperty
  a_init_clears: assert property (p_init_clears) else $error("init sequence wrong");

  property p_modes_distinct;
    user_mode |-> (state == st_user) && !user_io_pullup;
  endproperty
  a_modes_distinct: assert property (p_modes_distinct) else $error("mode mismatch");

  property p_reconfig;
    (state == st_user && !reconfig_request_n) |=> (state == st_reset_hold) ##1 !user_mode;
  endproperty
  a_reconfig: assert property (p_reconfig) else $error("reconfig ignored");

  property p_pullup;
    user_io_pullup == !user_io_enable;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up and enable overlap");

  property p_one_source;
    $onehot0({as_take, ps_take, scan_take});
  endproperty
  a_one_source: assert property (p_one_source) else $error("two schemes active");

  property p_as_clock;
    (as_take && !pend && bit_cnt != 5'h1f) |=> as_sclk;
  endproperty
  a_as_clock: assert property (p_as_clock) else $error("serial clock missing");

  property p_deadline;
    (in_load && load_timer == LIMIT_LAST && reconfig_request_n && !soft_reconfig)
      |=> (state == st_abort);
  endproperty
  a_deadline: assert property (p_deadline) else $error("load overran limit");

  property p_chain_out;
    $fell(chain_enable_out_n) |-> $past(state, 2) == st_load && load_done == 1'b1;
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain enable too early");

  property p_status_hold;
    (config_status_n_oe && reconfig_request_n && !soft_reconfig) |=> config_status_n_oe;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status released early");
endmodule // scl_sequencer

/* File: verif/scl_serial_mem.sv */
// Behavioural serial configuration memory for the load sequencer
`timescale 1ns/100ps
module scl_serial_mem #(
  parameter logic [31:0] BASE = 32'hc3a50000
) (
  // Serial link
  input wire logic as_sclk,
  input wire logic as_cs_n,
  output logic as_miso,
  // Status pin, low resets the stream
  input wire logic status_n
);
  int pos;
  logic fresh;
  logic [31:0] word;
  initial begin
    pos = 0;
    fresh = 1'b1;
    as_miso = 1'b0;
  end
  // ----------------------------------------------------------------
  // Word n holds BASE+n, sent MSB first
  // ----------------------------------------------------------------
  // Released line shows the inverse, so a stale bit is never read
  always @(negedge as_sclk or edge as_cs_n or negedge status_n) begin
    if (as_cs_n || !status_n) begin
      pos = 0;
      fresh = 1'b1;
      as_miso = ~as_miso;
    end else begin
      if (fresh)
        fresh = 1'b0;
      else
        pos = pos + 1;
      word = BASE + 32'(pos / 32);
      as_miso = word[31 - (pos % 32)];
    end
  end
endmodule // scl_serial_mem

/* File: verif/scl_sequencer_bench.sv */
// Self-checking bench for the configuration load sequencer
`timescale 1ns/100ps
module scl_sequencer_bench;
  import scl_pkg::*;
  localparam int WORDS = 4;
  localparam int LIMIT = 20000;
  localparam int TMO = 40000;
  localparam logic [31:0] MEM_BASE = 32'hc3a50000;
  localparam logic [31:0] HOST_BASE = 32'h5a5a0000;
  localparam logic [31:0] SCAN_BASE = 32'h3c3c0000;
  logic clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, exp_base, d;
  logic chain_enable_in_n, chain_enable_out_n, reconfig_request_n, config_status_n_in;
  logic config_status_n_out, config_status_n_oe, as_sclk, as_cs_n, as_miso;
  logic ps_dclk, ps_data, load_ready, scan_bit, scan_bit_valid, cs_seen;
  logic store_wr_valid, store_wr_ready, store_clear, user_mode, user_io_pullup, user_io_enable;
  scl_store_wr_t store_wr;
  int cyc, n_checks, miscompares, n_words, n_clear, t_out, t_user;

  // Open-drain status pin with its pull-up
  assign config_status_n_in = config_status_n_oe ? config_status_n_out : 1'b1;

  scl_sequencer #(.CFG_WORDS(WORDS), .LOAD_LIMIT_CYCLES(LIMIT)) u_dut (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .chain_enable_in_n,
    .chain_enable_out_n, .reconfig_request_n, .config_status_n_in, .config_status_n_out,
    .config_status_n_oe, .as_sclk, .as_cs_n, .as_miso, .ps_dclk, .ps_data, .load_ready,
    .scan_bit, .scan_bit_valid, .store_wr, .store_wr_valid, .store_wr_ready,
    .store_clear, .user_mode, .user_io_pullup, .user_io_enable);

  scl_serial_mem #(.BASE(MEM_BASE)) u_mem (
    .as_sclk, .as_cs_n, .as_miso, .status_n(config_status_n_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Store sink, stalls every third cycle, and timeout
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    store_wr_ready <= (cyc % 3 != 0);
    if (store_wr_valid === 1'b1 && store_wr_ready === 1'b1) begin
      check("store_word", store_wr.data, exp_base + 32'(store_wr.addr));
      n_words++;
    end
    if (store_clear === 1'b1)
      n_clear++;
    if (as_cs_n === 1'b0)
      cs_seen = 1'b1;
    if ($fell(chain_enable_out_n))
      t_out = cyc;
    if ($rose(user_mode))
      t_user = cyc;
    if (cyc == TMO) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus cycles and waits
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_state(input logic [2:0] code);
    do
      bus(1'b0, SCL_OFS_STATUS, 32'h0);
    while (d[2:0] !== code);
  endtask

  task automatic wait_user();
    while (user_mode !== 1'b1)
      @(posedge clk_sys);
    @(posedge clk_sys);
  endtask

  task automatic pulse_request();
    reconfig_request_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("pulse_user", 32'(user_mode), 32'h0);
    check("pulse_pullup", 32'(user_io_pullup), 32'h1);
    reconfig_request_n <= 1'b1;
  endtask

  task automatic t_powerup();
    repeat (3) @(posedge clk_sys);
    check("pu_user", 32'(user_mode), 32'h0);
    check("pu_pullup", 32'(user_io_pullup), 32'h1);
    check("pu_chain", 32'(chain_enable_out_n), 32'h1);
    bus(1'b0, SCL_OFS_STATUS, 32'h0);
    check("pu_status", d, 32'h1);
    exp_base = MEM_BASE;
    chain_enable_in_n <= 1'b0;
  endtask

  task automatic t_active();
    wait_user();
    check("as_words", n_words, WORDS);
    check("as_clear", n_clear, 1);
    check("as_init", t_user - t_out, SCL_INIT_CYCLES);
    check("as_io", 32'(user_io_enable), 32'h1);
    check("as_chain", 32'(chain_enable_out_n), 32'h0);
    check("as_time", 32'(t_out < LIMIT), 32'h1);
    bus(1'b0, SCL_OFS_STATUS, 32'h0);
    check("as_status", d, 32'h0004004c);
  endtask

  task automatic t_passive();
    bus(1'b1, SCL_OFS_CTRL, 32'h1);
    exp_base = HOST_BASE;
    cs_seen = 1'b0;
    pulse_request();
    wait_state(3'h2);
    n_words = 0;
    check("ps_ready", 32'(load_ready), 32'h1);
    for (int b = 31; b >= 0; b--) begin
      @(posedge clk_sys);
      ps_data <= HOST_BASE[b];
      ps_dclk <= 1'b1;
      @(posedge clk_sys);
      ps_dclk <= 1'b0;
    end
    for (int i = 1; i < WORDS; i++)
      bus(1'b1, SCL_OFS_DATA, HOST_BASE + 32'(i));
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    check("unmapped", d, 32'h0);
    wait_user();
    check("ps_words", n_words, WORDS);
    check("ps_ready_off", 32'(load_ready), 32'h0);
    check("ps_no_serial", 32'(cs_seen), 32'h0);
  endtask

  task automatic t_scan();
    logic [31:0] w;
    exp_base = SCAN_BASE;
    bus(1'b1, SCL_OFS_CTRL, 32'h6);
    wait_state(3'h2);
    n_words = 0;
    for (int i = 0; i < WORDS; i++) begin
      w = SCAN_BASE + 32'(i);
      for (int b = 31; b >= 0; b--) begin
        @(posedge clk_sys);
        scan_bit <= w[b];
        scan_bit_valid <= 1'b1;
      end
      // One idle cycle while the full word is handed on
      @(posedge clk_sys);
      scan_bit_valid <= 1'b0;
    end
    wait_user();
    check("scan_words", n_words, WORDS);
    bus(1'b0, SCL_OFS_CTRL, 32'h0);
    check("ctrl_read", d, 32'h2);
  endtask

  task automatic t_abort();
    exp_base = MEM_BASE;
    bus(1'b1, SCL_OFS_CTRL, 32'h4);
    wait_state(3'h2);
    bus(1'b1, SCL_OFS_CTRL, 32'h8);
    while (config_status_n_oe !== 1'b1)
      @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    check("ab_held", 32'(config_status_n_oe), 32'h1);
    check("ab_chain", 32'(chain_enable_out_n), 32'h1);
    check("ab_drive", 32'(config_status_n_in), 32'h0);
    bus(1'b0, SCL_OFS_STATUS, 32'h0);
    check("ab_status", d & 32'hffff, 32'h76);
    n_words = 0;
    pulse_request();
    repeat (2) @(posedge clk_sys);
    check("ab_release", 32'(config_status_n_oe), 32'h0);
    wait_user();
    check("ab_reload", n_words, WORDS);
  endtask

  task automatic t_limit();
    bus(1'b1, SCL_OFS_CTRL, 32'h7);
    wait_state(3'h6);
    check("bad_scheme", 32'(d[SCL_STAT_ERROR_BIT]), 32'h1);
    bus(1'b1, SCL_OFS_CTRL, 32'h5);
    wait_state(3'h2);
    repeat (LIMIT - 100) @(posedge clk_sys);
    check("lim_early", 32'(config_status_n_oe), 32'h0);
    repeat (200) @(posedge clk_sys);
    check("lim_abort", 32'(config_status_n_oe), 32'h1);
  endtask

  initial begin
    {cyc, n_checks, miscompares, n_words, n_clear, t_out, t_user} = '0;
    {reset, chain_enable_in_n, reconfig_request_n, avs_byteenable} = 7'h7f;
    {avs_read, avs_write, ps_dclk, ps_data, scan_bit, scan_bit_valid} = 6'h0;
    {avs_address, avs_writedata, exp_base, store_wr_ready, cs_seen} = '0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_powerup();
    t_active();
    t_passive();
    t_scan();
    t_abort();
    t_limit();
    print_verdict();
  end
endmodule // scl_sequencer_bench
